// file: hw/occ_defines.svh
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OCC_IDX_PWDN 8'h1E
`define OCC_IDX_CH0 8'h1F
`define OCC_IDX_CH1 8'h20
`define OCC_IDX_DIV 8'h21
`define OCC_IDX_STAT 8'h22

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCC_MUX_BIT 7
`define OCC_FMT_HI 6
`define OCC_FMT_LO 5
`define OCC_M1_HI 4
`define OCC_M1_LO 3
`define OCC_M2_HI 2
`define OCC_M2_LO 1
`define OCC_PWDN_BIT 0
`define OCC_STAT_LEVEL_BIT 0
`define OCC_STAT_PWDN_BIT 1
`define OCC_STAT_CH0_BIT 2
`define OCC_STAT_CH1_BIT 3
`define OCC_STAT_SRC_BIT 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCC_MUX_RST 1'b1
`define OCC_FMT_RST 2'h1
`define OCC_M1_RST 2'h2
`define OCC_M2_RST 2'h0
`define OCC_DIV_RST 8'h01
`define OCC_PWDN_RST 1'b0

`endif

// file: hw/occ_pkg.sv
package occ_pkg;

    // ------------------------------------------------------------
    // Driver encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OCC_FMT_OFF,
        OCC_FMT_ACDIFF,
        OCC_FMT_HCSL,
        OCC_FMT_CMOS
    } occ_format_type;

    typedef enum logic [1:0] {
        OCC_SE_TRI,
        OCC_SE_LOW,
        OCC_SE_INV,
        OCC_SE_NONINV
    } occ_semode_type;

    typedef enum logic [1:0] {
        OCC_TAIL_4MA,
        OCC_TAIL_6MA,
        OCC_TAIL_8MA,
        OCC_TAIL_16MA
    } occ_tail_type;

    typedef enum logic [1:0] {
        OCC_LOAD_TRI,
        OCC_LOAD_50,
        OCC_LOAD_100,
        OCC_LOAD_200
    } occ_load_type;

    // ------------------------------------------------------------
    // State records
    // ------------------------------------------------------------
    typedef struct packed {
        occ_format_type format;
        logic [1:0] modeOne;
        logic [1:0] modeTwo;
    } occ_chan_type;

    typedef struct packed {
        logic trueOut;
        logic trueOe;
        logic compOut;
        logic compOe;
        occ_tail_type tail;
        occ_load_type load;
        logic active;
    } occ_pins_type;

    typedef struct packed {
        logic [7:0] count;
        logic level;
        logic tick;
    } occ_div_type;

    typedef struct packed {
        logic pairSourceSelect;
        occ_chan_type ch0;
        occ_chan_type ch1;
        logic [7:0] divRatio;
        logic pairPowerDown;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        occ_pins_type pins0;
        occ_pins_type pins1;
    } occ_state_type;

endpackage

// file: hw/occ_divider.sv
`timescale 1ns/1ps

module occ_divider #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic tickIn,
    input wire logic [WIDTH-1:0] ratio,
    output logic divLevel,
    output logic divTick
);
    import occ_pkg::*;

    occ_div_type state_reg;
    occ_div_type state_next;
    logic [WIDTH:0] halfCount;

    // ------------------------------------------------------------
    // Counter: ratio plus one source ticks per output period
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        halfCount = ({1'b0, ratio} + (WIDTH+1)'(2)) >> 1;
        state_next.tick = 1'b0;
        if (!enable) begin
            // Power-down parks the counter so restart is phase clean
            state_next.count = '0;
            state_next.level = 1'b0;
        end else if (ratio == '0) begin
            // Divide by one: no room to shape, the tick is the clock
            state_next.count = '0;
            state_next.level = tickIn;
            state_next.tick = tickIn;
        end else if (tickIn) begin
            if (state_reg.count >= ratio) begin
                state_next.count = '0;
                state_next.tick = 1'b1;
            end else begin
                state_next.count = state_reg.count + WIDTH'(1);
            end
            state_next.level = {1'b0, state_next.count} < halfCount;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign divLevel = state_reg.level;
    assign divTick = state_reg.tick;

endmodule

// file: hw/occ_driver.sv
`timescale 1ns/1ps

module occ_driver (
    input occ_pkg::occ_chan_type config_i,
    input wire logic clkLevel,
    output occ_pkg::occ_pins_type pins
);
    import occ_pkg::*;

    // ------------------------------------------------------------
    // Single-ended pin: {enable, level}
    // ------------------------------------------------------------
    function automatic logic [1:0] seDrive(input logic [1:0] mode,
                                           input logic clk);
        logic [1:0] res;
        res = 2'h0;
        case (occ_semode_type'(mode))
            OCC_SE_TRI: res = 2'h0;
            OCC_SE_LOW: res = 2'h2;
            OCC_SE_INV: res = {1'b1, ~clk};
            OCC_SE_NONINV: res = {1'b1, clk};
            default: res = 2'h0;
        endcase
        return res;
    endfunction

    logic [1:0] trueSe;
    logic [1:0] compSe;

    always_comb begin
        trueSe = seDrive(config_i.modeOne, clkLevel);
        compSe = seDrive(config_i.modeTwo, clkLevel);
        pins = '0;
        pins.tail = OCC_TAIL_4MA;
        pins.load = OCC_LOAD_TRI;
        case (config_i.format)
            OCC_FMT_OFF: begin
                pins = '0;
            end
            OCC_FMT_ACDIFF: begin
                pins.trueOut = clkLevel;
                pins.trueOe = 1'b1;
                pins.compOut = ~clkLevel;
                pins.compOe = 1'b1;
                pins.tail = occ_tail_type'(config_i.modeOne);
                pins.active = 1'b1;
            end
            OCC_FMT_HCSL: begin
                pins.trueOut = clkLevel;
                pins.trueOe = 1'b1;
                pins.compOut = ~clkLevel;
                pins.compOe = 1'b1;
                pins.tail = occ_tail_type'(config_i.modeOne);
                pins.load = occ_load_type'(config_i.modeTwo);
                pins.active = 1'b1;
            end
            OCC_FMT_CMOS: begin
                pins.trueOe = trueSe[1];
                pins.trueOut = trueSe[0];
                pins.compOe = compSe[1];
                pins.compOut = compSe[0];
                pins.active = trueSe[1] | compSe[1];
            end
            default: pins = '0;
        endcase
    end

endmodule

// file: hw/occ_top.sv
// Functional notes
// - Mux bit 0 feeds both channels from synth one, 1 from two; resets 1.
// - Channel 0 format: off, AC differential, HCSL, LVCMOS; resets to 1.
// - Channel 1 has its own format field, bits 6:5, same codes, reset 1.
// - Mode-one in LVCMOS drives true pin: tri, low, inverted, true; reset 2.
// - Mode-one in differential picks tail current 4, 6, 8, 16/8 mA.
// - Mode-two drives complement pin in LVCMOS, HCSL load in HCSL only; reset 0.
// - Channel 1 has own mode-one and mode-two, resets 2 and 0.
// - One shared 8-bit divider divides by stored value plus one.
// - Divider register resets to 0x01, dividing by two.
// - Power-down stops the divider only, not the mux; drivers stop only with format 0 or with both LVCMOS pins tri.
`timescale 1ns/1ps
`include "occ_defines.svh"

module occ_top #(
    parameter int ADDR_WIDTH = 12,
    parameter int DIV_WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic synthTickOne,
    input wire logic synthTickTwo,
    output logic pairDivTick,
    output logic ch0TrueOut,
    output logic ch0TrueOe,
    output logic ch0CompOut,
    output logic ch0CompOe,
    output occ_pkg::occ_tail_type ch0TailSel,
    output occ_pkg::occ_load_type ch0LoadSel,
    output logic ch1TrueOut,
    output logic ch1TrueOe,
    output logic ch1CompOut,
    output logic ch1CompOe,
    output occ_pkg::occ_tail_type ch1TailSel,
    output occ_pkg::occ_load_type ch1LoadSel
);
    import occ_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic regHit(input logic [ADDR_WIDTH-1:0] addr,
                                    input logic [7:0] idx);
        logic [ADDR_WIDTH-1:0] byteAddr;
        byteAddr = ADDR_WIDTH'({idx, 2'b00});
        return addr == byteAddr;
    endfunction

    function automatic logic [7:0] packChan(input occ_chan_type ch,
                                            input logic muxBit);
        logic [7:0] word;
        word = 8'h00;
        word[`OCC_MUX_BIT] = muxBit;
        word[`OCC_FMT_HI:`OCC_FMT_LO] = ch.format;
        word[`OCC_M1_HI:`OCC_M1_LO] = ch.modeOne;
        word[`OCC_M2_HI:`OCC_M2_LO] = ch.modeTwo;
        return word;
    endfunction

    function automatic occ_chan_type unpackChan(input logic [31:0] data);
        occ_chan_type ch;
        ch.format = occ_format_type'(data[`OCC_FMT_HI:`OCC_FMT_LO]);
        ch.modeOne = data[`OCC_M1_HI:`OCC_M1_LO];
        ch.modeTwo = data[`OCC_M2_HI:`OCC_M2_LO];
        return ch;
    endfunction

    // ------------------------------------------------------------
    // State and submodule wiring
    // ------------------------------------------------------------
    occ_state_type state_reg;
    occ_state_type state_next;
    logic srcTick;
    logic divEnable;
    logic divLevel;
    logic divTick;
    logic accessCycle;
    logic commitCycle;
    occ_pins_type drivePins0;
    occ_pins_type drivePins1;
    logic [7:0] statusWord;

    // ------------------------------------------------------------
    // Source mux and shared divider
    // ------------------------------------------------------------
    always_comb begin
        if (state_reg.pairSourceSelect) begin
            srcTick = synthTickTwo;
        end else begin
            srcTick = synthTickOne;
        end
        // Pair power-down disables the divider; the mux keeps passing ticks
        divEnable = ~state_reg.pairPowerDown;
    end

    occ_divider #(
        .WIDTH(DIV_WIDTH)
    ) u_divider (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enable(divEnable),
        .tickIn(srcTick),
        .ratio(state_reg.divRatio),
        .divLevel(divLevel),
        .divTick(divTick)
    );

    // ------------------------------------------------------------
    // Per-channel driver decode
    // ------------------------------------------------------------
    occ_driver u_driver0 (
        .config_i(state_reg.ch0),
        .clkLevel(divLevel),
        .pins(drivePins0)
    );

    occ_driver u_driver1 (
        .config_i(state_reg.ch1),
        .clkLevel(divLevel),
        .pins(drivePins1)
    );

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    always_comb begin
        statusWord = 8'h00;
        statusWord[`OCC_STAT_LEVEL_BIT] = divLevel;
        statusWord[`OCC_STAT_PWDN_BIT] = state_reg.pairPowerDown;
        statusWord[`OCC_STAT_CH0_BIT] = state_reg.pins0.active;
        statusWord[`OCC_STAT_CH1_BIT] = state_reg.pins1.active;
        statusWord[`OCC_STAT_SRC_BIT] = state_reg.pairSourceSelect;
    end

    // ------------------------------------------------------------
    // APB slave and register file
    // ------------------------------------------------------------
    // One wait state: data and error are registered in the first
    // access cycle, so every output stays a flop.
    always_comb begin
        state_next = state_reg;
        accessCycle = psel && penable && !state_reg.pready;
        commitCycle = psel && penable && state_reg.pready;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        if (accessCycle) begin
            state_next.pready = 1'b1;
            state_next.prdata = 32'h0000_0000;
            if (regHit(paddr, `OCC_IDX_PWDN)) begin
                state_next.prdata[`OCC_PWDN_BIT] =
                    state_reg.pairPowerDown;
            end else if (regHit(paddr, `OCC_IDX_CH0)) begin
                state_next.prdata[7:0] =
                    packChan(state_reg.ch0, state_reg.pairSourceSelect);
            end else if (regHit(paddr, `OCC_IDX_CH1)) begin
                // Bit 7 of channel 1 is reserved
                state_next.prdata[7:0] =
                    packChan(state_reg.ch1, 1'b0);
            end else if (regHit(paddr, `OCC_IDX_DIV)) begin
                state_next.prdata[7:0] = state_reg.divRatio;
            end else if (regHit(paddr, `OCC_IDX_STAT)) begin
                state_next.prdata[7:0] = statusWord;
            end else begin
                state_next.pslverr = 1'b1;
            end
        end
        if (commitCycle && pwrite) begin
            if (regHit(paddr, `OCC_IDX_PWDN)) begin
                state_next.pairPowerDown = pwdata[`OCC_PWDN_BIT];
            end else if (regHit(paddr, `OCC_IDX_CH0)) begin
                state_next.pairSourceSelect = pwdata[`OCC_MUX_BIT];
                state_next.ch0 = unpackChan(pwdata);
            end else if (regHit(paddr, `OCC_IDX_CH1)) begin
                state_next.ch1 = unpackChan(pwdata);
            end else if (regHit(paddr, `OCC_IDX_DIV)) begin
                state_next.divRatio = pwdata[7:0];
            end
        end
        // Pins follow the driver decode one cycle later
        state_next.pins0 = drivePins0;
        state_next.pins1 = drivePins1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.pairSourceSelect <= `OCC_MUX_RST;
            state_reg.ch0.format <= occ_format_type'(`OCC_FMT_RST);
            state_reg.ch0.modeOne <= `OCC_M1_RST;
            state_reg.ch0.modeTwo <= `OCC_M2_RST;
            state_reg.ch1.format <= occ_format_type'(`OCC_FMT_RST);
            state_reg.ch1.modeOne <= `OCC_M1_RST;
            state_reg.ch1.modeTwo <= `OCC_M2_RST;
            state_reg.divRatio <= `OCC_DIV_RST;
            state_reg.pairPowerDown <= `OCC_PWDN_RST;
            state_reg.pins0.tail <= OCC_TAIL_4MA;
            state_reg.pins1.tail <= OCC_TAIL_4MA;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = state_reg.pready;
    assign prdata = state_reg.prdata;
    assign pslverr = state_reg.pslverr;
    assign pairDivTick = divTick;
    assign ch0TrueOut = state_reg.pins0.trueOut;
    assign ch0TrueOe = state_reg.pins0.trueOe;
    assign ch0CompOut = state_reg.pins0.compOut;
    assign ch0CompOe = state_reg.pins0.compOe;
    assign ch0TailSel = state_reg.pins0.tail;
    assign ch0LoadSel = state_reg.pins0.load;
    assign ch1TrueOut = state_reg.pins1.trueOut;
    assign ch1TrueOe = state_reg.pins1.trueOe;
    assign ch1CompOut = state_reg.pins1.compOut;
    assign ch1CompOe = state_reg.pins1.compOe;
    assign ch1TailSel = state_reg.pins1.tail;
    assign ch1LoadSel = state_reg.pins1.load;

endmodule

// file: tb/occ_top_props.sv
`timescale 1ns/1ps

module occ_top_props
    import occ_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int DIV_WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic pairDivTick,
    input wire logic ch0TrueOut,
    input wire logic ch0TrueOe,
    input wire logic ch0CompOut,
    input wire logic ch0CompOe,
    input occ_pkg::occ_tail_type ch0TailSel,
    input occ_pkg::occ_load_type ch0LoadSel,
    input occ_pkg::occ_tail_type ch1TailSel
);
    // ----------------------------------------------------------------
    // Shadow of committed settings
    // ----------------------------------------------------------------
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic pwdn;
    logic commit;
    logic mapped;
    assign commit = psel & penable & pready & pwrite;
    assign mapped = paddr inside {12'h078, 12'h07C, 12'h080, 12'h084,
        12'h088};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl0 <= 8'hB0;
            ctl1 <= 8'h30;
            pwdn <= 1'b0;
        end else if (commit) begin
            if (paddr == 12'h07C) ctl0 <= pwdata[7:0];
            if (paddr == 12'h080) ctl1 <= pwdata[7:0];
            if (paddr == 12'h078) pwdn <= pwdata[0];
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Pins lag the register by one edge, so only settled settings count
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_ready_latency: assert property (psel && !penable ##1
        psel && penable && !pready |=> pready)
        else $error("pready not in second access cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    chk_read_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_off_quiet: assert property ($stable(ctl0) && ctl0[6:5] == 2'h0
        |-> !ch0TrueOe && !ch0CompOe)
        else $error("disabled channel still driving");
    chk_tail_diff: assert property ($past(rst_n) && $stable(ctl0)
        |-> ch0TailSel ==
        ((ctl0[6:5] == 2'h1 || ctl0[6:5] == 2'h2) ? ctl0[4:3] : 2'h0))
        else $error("channel 0 tail code wrong");
    chk_load_hcsl: assert property ($stable(ctl0) |-> ch0LoadSel ==
        (ctl0[6:5] == 2'h2 ? ctl0[2:1] : 2'h0))
        else $error("channel 0 load code wrong");
    chk_cmos_pol: assert property ($stable(ctl0) && ctl0[6:1] == 6'h3E
        |-> ch0TrueOe && ch0CompOe && ch0TrueOut != ch0CompOut)
        else $error("single-ended pins not opposite");
    chk_true_tri: assert property ($stable(ctl0) && ctl0[6:3] == 4'hC
        |-> !ch0TrueOe)
        else $error("true pin not tri-stated");
    chk_ch1_tail: assert property ($past(rst_n) && $stable(ctl1)
        |-> ch1TailSel ==
        ((ctl1[6:5] == 2'h1 || ctl1[6:5] == 2'h2) ? ctl1[4:3] : 2'h0))
        else $error("channel 1 tail code wrong");
    chk_pwdn_quiet: assert property (pwdn && $past(pwdn, 2)
        |-> !pairDivTick)
        else $error("divider ticks while powered down");
endmodule

bind occ_top occ_top_props #(.ADDR_WIDTH(ADDR_WIDTH), .DIV_WIDTH(DIV_WIDTH))
    u_props (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .pairDivTick, .ch0TrueOut, .ch0TrueOe,
    .ch0CompOut, .ch0CompOe, .ch0TailSel, .ch0LoadSel, .ch1TailSel);

// file: tb/occ_top_tb.sv
`timescale 1ns/1ps
`include "occ_defines.svh"

module occ_top_tb;
    import occ_pkg::*;
    typedef struct packed {
        logic rd;
        logic err;
        logic [31:0] data;
    } occ_note_type;
    localparam logic [11:0] A_PD = {2'b00, `OCC_IDX_PWDN, 2'b00};
    localparam logic [11:0] A_C0 = {2'b00, `OCC_IDX_CH0, 2'b00};
    localparam logic [11:0] A_C1 = {2'b00, `OCC_IDX_CH1, 2'b00};
    localparam logic [11:0] A_DV = {2'b00, `OCC_IDX_DIV, 2'b00};
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic synthTickOne, synthTickTwo, pairDivTick, ch0TrueOe, ch0CompOe;
    logic ch1TrueOut, ch1TrueOe, ch1CompOut, ch1CompOe;
    occ_tail_type ch0TailSel, ch1TailSel;
    occ_load_type ch0LoadSel, ch1LoadSel;
    occ_note_type notes[$];
    int n_mismatch = 0;
    int compares = 0;
    int seed = 49;

    occ_top dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .synthTickOne, .synthTickTwo,
        .pairDivTick, .ch0TrueOut(), .ch0TrueOe, .ch0CompOut(), .ch0CompOe,
        .ch0TailSel, .ch0LoadSel, .ch1TrueOut, .ch1TrueOe,
        .ch1CompOut, .ch1CompOe, .ch1TailSel, .ch1LoadSel);

    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task automatic final_report;
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check_bus(input occ_note_type n, input logic [31:0] d,
        input logic e);
        compares++;
        if (e !== n.err || (n.rd && !n.err && d !== n.data)) begin
            n_mismatch++;
            $display("unexpected at %0t: bus %h/%b", $time, d, e);
        end
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Release only after the answering edge, never twice per step
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] exp);
        occ_note_type n;
        int i;
        n.rd = !wr;
        n.data = exp;
        n.err = !(a inside {A_PD, A_C0, A_C1, A_DV, 12'h088});
        @(posedge clk_sys);
        notes.push_back(n);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            final_report;
        end
    endtask
    task automatic ticks(input int cyc, output int n, output int gap);
        n = 0;
        gap = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            gap++;
            if (pairDivTick === 1'b1 && n++ >= 1) break;
            if (pairDivTick === 1'b1) gap = 0;
        end
    endtask

    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                n_mismatch++;
                $display("unexpected at %0t: stray pready", $time);
            end else check_bus(notes.pop_front(), prdata, pslverr);
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int k, n, gap;
        int rs[6];
        logic [31:0] d;
        logic [1:0] f;
        rs = '{0, 1, 2, 7, 255, 0};
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {synthTickOne, synthTickTwo} = 2'b00;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(0, A_C0, 0, 32'hB0);
        apb(0, A_C1, 0, 32'h30);
        apb(0, A_DV, 0, 32'h01);
        apb(0, A_PD, 0, 32'h00);
        apb(0, 12'h088, 0, 32'h1C);
        apb(1, 12'h08C, 32'hFF, 0);
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            apb(1, A_C0, d, 0);
            apb(0, A_C0, 0, d & 32'hFE);
            apb(1, A_C1, d, 0);
            apb(0, A_C1, 0, d & 32'h7E);
        end
        for (k = 0; k < 64; k++) begin
            apb(1, A_C0, k << 1, 0);
            apb(1, A_C1, k << 1, 0);
            repeat (2) @(posedge clk_sys);
            f = k[5:4];
            check_val(ch1TailSel, f == 1 || f == 2 ? k[3:2] : 0);
            check_val(ch0LoadSel, f == 2 ? k[1:0] : 0);
            check_val(ch1LoadSel, f == 2 ? k[1:0] : 0);
            check_val({ch0TrueOe, ch0CompOe},
                f == 0 ? 0 : f != 3 ? 3 : {k[3:2] != 0, k[1:0] != 0});
            check_val({ch1TrueOe, ch1CompOe, ch1TrueOut, ch1CompOut},
                f == 0 ? 0 : f != 3 ? 4'hD :
                {k[3:2] != 0, k[1:0] != 0, k[3:2] == 2, k[1:0] == 2});
        end
        // Selected source ticks every cycle so a period is R+1 cycles
        apb(1, A_C0, 32'h30, 0);
        synthTickOne <= 1'b1;
        rs[5] = $random(seed) & 32'hFF;
        for (k = 0; k < 6; k++) begin
            apb(1, A_DV, rs[k], 0);
            ticks(600, n, gap);
            check_val(gap, rs[k] + 1);
        end
        apb(1, A_C0, 32'hB0, 0);
        // A tick launched from the old source may still be in flight
        @(posedge clk_sys);
        ticks(300, n, gap);
        check_val(n, 0);
        synthTickTwo <= 1'b1;
        ticks(600, n, gap);
        check_val(gap, rs[5] + 1);
        apb(1, A_PD, 1, 0);
        repeat (4) @(posedge clk_sys);
        ticks(300, n, gap);
        check_val(n, 0);
        check_val({ch0TrueOe, ch0CompOe}, 3);
        apb(1, A_PD, 0, 0);
        ticks(600, n, gap);
        check_val(gap, rs[5] + 1);
        final_report;
    end
endmodule
